// ==== src/irq_ctrl.sv ====
/*
  two-level interrupt controller: source flags, sampling, polling,
  vectoring, in-progress markers and the four enable/priority registers.
  assumes the core gives a sample strobe once per machine cycle, a poll
  slot on the last cycle of each instruction, and a return strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // special-function register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  // external pins, active low
  input wire logic EXT0_PIN_N,
  input wire logic EXT1_PIN_N,
  input wire logic TIMER2_EXT_PIN,
  // timer control bits held by the core
  input wire logic EDGE_SELECT_0,
  input wire logic EDGE_SELECT_1,
  // peripheral flags
  input wire logic TIMER0_OVERFLOW_FLAG,
  input wire logic TIMER0_MODE3,
  input wire logic TIMER1_OVERFLOW_FLAG,
  input wire logic TIMER2_OVERFLOW_FLAG,
  input wire logic TIMER2_EXT_ENABLE,
  input wire logic TIMER2_EXT_FLAG_CLR,
  input wire logic SERIAL2_EVENT_FLAG,
  input wire logic RECEIVE_DONE_FLAG_1,
  input wire logic TRANSMIT_DONE_FLAG_1,
  input wire logic RECEIVE_DONE_FLAG_2,
  input wire logic TRANSMIT_DONE_FLAG_2,
  input wire logic ADC_TAKEOVER,
  input wire logic ADC_DONE_FLAG,
  // core sequencing
  input wire logic MC_SAMPLE,
  input wire logic POLL_SLOT,
  input wire logic RETURN_FROM_IRQ,
  // acknowledge
  output logic IRQ_ACK,
  output logic [15:0] IRQ_VECTOR,
  // flags and hardware clears
  output logic EXT_REQUEST_FLAG_0,
  output logic EXT_REQUEST_FLAG_1,
  output logic TIMER2_EXT_FLAG,
  output logic TIMER0_FLAG_CLR,
  output logic TIMER1_FLAG_CLR,
  output logic SERIAL2_EVENT_CLR,
  // in-progress markers
  output logic IN_PROGRESS_HI,
  output logic IN_PROGRESS_LO
);
  // ==========================================================
  // registers
  logic [7:0] en_main_q; // main enable
  logic [7:0] en_ext_q; // secondary enable
  logic [7:0] prio_main_q; // main priority
  logic [7:0] prio_ext_q; // secondary priority
  logic [7:0] rdata_q; // read data
  logic ext0_q; // external request flag zero
  logic ext1_q; // external request flag one
  logic timer2_ext_flag_q; // timer two pin flag
  logic [9:0] sample_q; // requests caught at the sample strobe
  logic ack_q; // acknowledge pulse
  logic [15:0] vec_q; // vector address
  logic tf0_clr_q; // timer zero clear pulse
  logic tf1_clr_q; // timer one clear pulse
  logic tw_clr_q; // two-wire clear pulse
  logic busy_hi_q; // high routine in progress
  logic busy_lo_q; // low routine in progress
  logic pin0_prev_q; // previous filtered pin levels
  logic pin1_prev_q;
  logic t2x_prev_q;

  // ==========================================================
  // pin conditioning
  logic pin0_lvl; // filtered pin levels
  logic pin1_lvl;
  logic t2x_lvl;

  pin_sync u_sync0
  (
    .clk(SYS_CLK),
    .srst(SRST),
    .pin(EXT0_PIN_N),
    .idle_level(1'b1),
    .level_q(pin0_lvl)
  );

  pin_sync u_sync1
  (
    .clk(SYS_CLK),
    .srst(SRST),
    .pin(EXT1_PIN_N),
    .idle_level(1'b1),
    .level_q(pin1_lvl)
  );

  pin_sync u_sync2
  (
    .clk(SYS_CLK),
    .srst(SRST),
    .pin(TIMER2_EXT_PIN),
    .idle_level(1'b1),
    .level_q(t2x_lvl)
  );

  // edge history of the filtered pins
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      pin0_prev_q <= 1'b1;
      pin1_prev_q <= 1'b1;
      t2x_prev_q <= 1'b1;
    end
    else
    begin
      pin0_prev_q <= pin0_lvl;
      pin1_prev_q <= pin1_lvl;
      t2x_prev_q <= t2x_lvl;
    end
  end

  logic fall0; // falling transitions
  logic fall1;
  logic fall_t2x;
  assign fall0 = pin0_prev_q & ~pin0_lvl;
  assign fall1 = pin1_prev_q & ~pin1_lvl;
  assign fall_t2x = t2x_prev_q & ~t2x_lvl;

  // ==========================================================
  // register port
  // local names for the poll positions, declared before the lookups
  localparam logic [3:0] POS_EXT0 = irq_ctrl_pkg::POS_EXT0;
  localparam logic [3:0] POS_SERIAL2 = irq_ctrl_pkg::POS_SERIAL2;
  localparam logic [3:0] POS_TIMER0 = irq_ctrl_pkg::POS_TIMER0;
  localparam logic [3:0] POS_TWO_WIRE = irq_ctrl_pkg::POS_TWO_WIRE;
  localparam logic [3:0] POS_EXT1 = irq_ctrl_pkg::POS_EXT1;
  localparam logic [3:0] POS_TIMER1 = irq_ctrl_pkg::POS_TIMER1;
  localparam logic [3:0] POS_SERIAL1 = irq_ctrl_pkg::POS_SERIAL1;
  localparam logic [3:0] POS_TIMER2 = irq_ctrl_pkg::POS_TIMER2;

  // map each position to its bit in the four registers
  function automatic logic [9:0] spread(input logic [7:0] m, input logic [7:0] x);
    logic [9:0] v;
    v = 10'h000;
    v[POS_EXT0] = m[irq_ctrl_pkg::EXT0_BIT];
    v[POS_SERIAL2] = x[irq_ctrl_pkg::SERIAL2_BIT];
    v[POS_TIMER0] = m[irq_ctrl_pkg::TIMER0_BIT];
    v[POS_TWO_WIRE] = x[irq_ctrl_pkg::TWO_WIRE_BIT];
    v[POS_EXT1] = m[irq_ctrl_pkg::EXT1_BIT];
    v[POS_TIMER1] = m[irq_ctrl_pkg::TIMER1_BIT];
    v[POS_SERIAL1] = m[irq_ctrl_pkg::SERIAL_BIT];
    v[POS_TIMER2] = m[irq_ctrl_pkg::TIMER2_BIT];
    return v;
  endfunction

  // writes; unimplemented bits are never stored
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      en_main_q <= irq_ctrl_pkg::REG_RESET;
      en_ext_q <= irq_ctrl_pkg::REG_RESET;
      prio_main_q <= irq_ctrl_pkg::REG_RESET;
      prio_ext_q <= irq_ctrl_pkg::REG_RESET;
    end
    else if (SFR_WR)
    begin
      unique case (SFR_ADDR)
        irq_ctrl_pkg::ENABLE_MAIN_ADDR: // RULE_17 RULE_18
          en_main_q <= SFR_WDATA & irq_ctrl_pkg::MAIN_EN_MASK;
        irq_ctrl_pkg::ENABLE_EXT_ADDR: // RULE_12
          en_ext_q <= SFR_WDATA & irq_ctrl_pkg::EXT_MASK;
        irq_ctrl_pkg::PRIORITY_MAIN_ADDR: // RULE_19
          prio_main_q <= SFR_WDATA & irq_ctrl_pkg::MAIN_PRIO_MASK;
        irq_ctrl_pkg::PRIORITY_EXT_ADDR: // RULE_12 RULE_19
          prio_ext_q <= SFR_WDATA & irq_ctrl_pkg::EXT_MASK;
        default:
          ; // other addresses belong to other blocks
      endcase
    end
  end

  // reads one cycle after the strobe; other addresses read zero
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      rdata_q <= 8'h00;
    end
    else if (SFR_RD)
    begin
      unique case (SFR_ADDR)
        irq_ctrl_pkg::ENABLE_MAIN_ADDR: rdata_q <= en_main_q;
        irq_ctrl_pkg::ENABLE_EXT_ADDR: rdata_q <= en_ext_q;
        irq_ctrl_pkg::PRIORITY_MAIN_ADDR: rdata_q <= prio_main_q;
        irq_ctrl_pkg::PRIORITY_EXT_ADDR: rdata_q <= prio_ext_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // source flags
  logic ack_d; // acknowledge decision
  logic [3:0] win_idx; // winning position
  logic win_lvl; // winning level

  // external zero: level copies the pin, edge latches until vectored
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      ext0_q <= 1'b0;
    end
    else if (!EDGE_SELECT_0)
    begin
      ext0_q <= ~pin0_lvl; // RULE_02 RULE_04
    end
    else if (fall0)
    begin
      ext0_q <= 1'b1; // RULE_02 new edge beats the clear
    end
    else if (ack_d && win_idx == POS_EXT0)
    begin
      ext0_q <= 1'b0; // RULE_04
    end
  end

  // external one: same scheme on the second pin
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      ext1_q <= 1'b0;
    end
    else if (!EDGE_SELECT_1)
    begin
      ext1_q <= ~pin1_lvl; // RULE_03 RULE_04
    end
    else if (fall1)
    begin
      ext1_q <= 1'b1; // RULE_03
    end
    else if (ack_d && win_idx == POS_EXT1)
    begin
      ext1_q <= 1'b0; // RULE_04
    end
  end

  // timer two pin flag; only software clears it, a new edge wins
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      timer2_ext_flag_q <= 1'b0;
    end
    else if (fall_t2x && TIMER2_EXT_ENABLE)
    begin
      timer2_ext_flag_q <= 1'b1; // RULE_08
    end
    else if (TIMER2_EXT_FLAG_CLR)
    begin
      timer2_ext_flag_q <= 1'b0; // RULE_07
    end
  end

  // raw request per position; reserved positions stay zero
  logic [9:0] raw_req;
  always_comb
  begin
    raw_req = 10'h000; // RULE_01
    raw_req[POS_EXT0] = ext0_q;
    raw_req[POS_SERIAL2] = RECEIVE_DONE_FLAG_2 | TRANSMIT_DONE_FLAG_2; // RULE_11 RULE_12
    raw_req[POS_TIMER0] = TIMER0_OVERFLOW_FLAG & ~TIMER0_MODE3; // RULE_06
    raw_req[POS_TWO_WIRE] = SERIAL2_EVENT_FLAG; // RULE_09
    raw_req[POS_EXT1] = ADC_TAKEOVER ? ADC_DONE_FLAG : ext1_q; // RULE_10
    raw_req[POS_TIMER1] = TIMER1_OVERFLOW_FLAG; // RULE_06
    raw_req[POS_SERIAL1] = RECEIVE_DONE_FLAG_1 | TRANSMIT_DONE_FLAG_1; // RULE_11
    raw_req[POS_TIMER2] = TIMER2_OVERFLOW_FLAG | timer2_ext_flag_q; // RULE_07 RULE_08
  end

  // ==========================================================
  // sampling and polling
  // each strobe overwrites the samples, so a denied request is forgotten
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      sample_q <= 10'h000;
    end
    else if (MC_SAMPLE)
    begin
      sample_q <= raw_req; // RULE_20
    end
    else if (ack_d)
    begin
      sample_q[win_idx] <= 1'b0; // one call per sample
    end
  end

  logic [9:0] gated_req; // enabled samples
  logic [9:0] src_prio; // level per position
  logic pick_valid;
  assign gated_req = sample_q & spread(en_main_q, en_ext_q)
    & {10{en_main_q[irq_ctrl_pkg::GLOBAL_EN_BIT]}}; // RULE_16 RULE_17
  assign src_prio = spread(prio_main_q, prio_ext_q); // RULE_13 RULE_19

  irq_pick u_pick
  (
    .req(gated_req),
    .prio(src_prio),
    .busy_hi(busy_hi_q),
    .busy_lo(busy_lo_q),
    .valid(pick_valid),
    .idx(win_idx),
    .level(win_lvl)
  );

  // register writes block the poll slot, like the return itself
  assign ack_d = POLL_SLOT && pick_valid && !SFR_WR && !RETURN_FROM_IRQ; // RULE_15 RULE_20

  // vector lookup
  function automatic logic [15:0] vector_of(input logic [3:0] p);
    unique case (p)
      POS_EXT0: return irq_ctrl_pkg::VEC_EXT0;
      POS_SERIAL2: return irq_ctrl_pkg::VEC_SERIAL2;
      POS_TIMER0: return irq_ctrl_pkg::VEC_TIMER0;
      POS_TWO_WIRE: return irq_ctrl_pkg::VEC_TWO_WIRE;
      POS_EXT1: return irq_ctrl_pkg::VEC_EXT1;
      POS_TIMER1: return irq_ctrl_pkg::VEC_TIMER1;
      POS_SERIAL1: return irq_ctrl_pkg::VEC_SERIAL1;
      POS_TIMER2: return irq_ctrl_pkg::VEC_TIMER2;
      default: return irq_ctrl_pkg::VEC_NONE;
    endcase
  endfunction

  // acknowledge pulse, vector held until the next acknowledge
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      ack_q <= 1'b0;
      vec_q <= irq_ctrl_pkg::VEC_NONE;
    end
    else
    begin
      ack_q <= ack_d;
      if (ack_d)
      begin
        vec_q <= vector_of(win_idx); // RULE_21
      end
    end
  end

  // hardware clear pulses; serial and timer two get none
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      tf0_clr_q <= 1'b0;
      tf1_clr_q <= 1'b0;
      tw_clr_q <= 1'b0;
    end
    else
    begin
      tf0_clr_q <= ack_d && win_idx == POS_TIMER0; // RULE_06
      tf1_clr_q <= ack_d && win_idx == POS_TIMER1; // RULE_06
      tw_clr_q <= ack_d && win_idx == POS_TWO_WIRE; // RULE_09
    end
  end

  // ==========================================================
  // in-progress markers
  // a return clears the highest active level; acknowledge sets its own
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      busy_hi_q <= 1'b0;
      busy_lo_q <= 1'b0;
    end
    else if (ack_d)
    begin
      if (win_lvl)
      begin
        busy_hi_q <= 1'b1; // RULE_23
      end
      else
      begin
        busy_lo_q <= 1'b1; // RULE_23
      end
    end
    else if (RETURN_FROM_IRQ)
    begin
      if (busy_hi_q)
      begin
        busy_hi_q <= 1'b0; // RULE_22
      end
      else
      begin
        busy_lo_q <= 1'b0; // RULE_22
      end
    end
  end

  // ==========================================================
  // outputs
  assign SFR_RDATA = rdata_q;
  assign IRQ_ACK = ack_q;
  assign IRQ_VECTOR = vec_q;
  assign EXT_REQUEST_FLAG_0 = ext0_q;
  assign EXT_REQUEST_FLAG_1 = ext1_q;
  assign TIMER2_EXT_FLAG = timer2_ext_flag_q;
  assign TIMER0_FLAG_CLR = tf0_clr_q;
  assign TIMER1_FLAG_CLR = tf1_clr_q;
  assign SERIAL2_EVENT_CLR = tw_clr_q;
  assign IN_PROGRESS_HI = busy_hi_q;
  assign IN_PROGRESS_LO = busy_lo_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  global_gate_a: assert property (ack_q |-> $past(en_main_q[7])) // RULE_17
    else $error("acknowledge while globally disabled");
  hi_block_a: assert property (busy_hi_q |=> !ack_q) // RULE_14
    else $error("acknowledge during high routine");
  vector_ext0_a: assert property (ack_q && vec_q == 16'h0003 |-> $past(sample_q[0])) // RULE_21
    else $error("external zero vector without its sample");
  edge_clear_a: assert property (ack_q && vec_q == 16'h0003 && $past(EDGE_SELECT_0) // RULE_04
    && !$past(fall0) |-> !ext0_q)
    else $error("edge flag not cleared on vectoring");
  pin_flag_hold_a: assert property (timer2_ext_flag_q && !TIMER2_EXT_FLAG_CLR |=> timer2_ext_flag_q) // RULE_07
    else $error("timer two pin flag lost without software clear");
  timer0_clear_a: assert property (ack_q && vec_q == 16'h000b |-> tf0_clr_q) // RULE_06
    else $error("timer zero flag not cleared");
  return_clear_a: assert property (RETURN_FROM_IRQ && busy_hi_q && !ack_d |=> !busy_hi_q) // RULE_22
    else $error("return left high marker set");
  marker_set_a: assert property (ack_q |-> busy_hi_q || busy_lo_q) // RULE_23
    else $error("acknowledge without a marker");
  sample_take_a: assert property (MC_SAMPLE |=> sample_q == $past(raw_req)) // RULE_20
    else $error("sample not taken at strobe");

  ext0_call_c: cover property (ack_q && vec_q == 16'h0003);
  preempt_c: cover property (busy_lo_q && ack_q && busy_hi_q);
  return_c: cover property (RETURN_FROM_IRQ && busy_lo_q ##1 !busy_lo_q);
endmodule
`default_nettype wire

// ==== src/irq_ctrl_pkg.sv ====
/*
  constants for the two-level interrupt controller: register offsets,
  field positions, reset values, source positions and vectors.
  assumes a byte-wide special-function register port from the core.
*/
// Operation
// (RULE_01) ten source positions, two of them reserved
// (RULE_02) external zero flag: level or falling edge
// (RULE_03) external one flag: level or edge
// (RULE_04) edge mode flag cleared on vectoring only
// (RULE_05) level requester drops request before routine ends
// (RULE_06) timer zero/one flags, cleared on service
// (RULE_07) timer two overflow never cleared by hardware
// (RULE_08) timer two pin flag ORed into request
// (RULE_09) two-wire event flag, cleared by hardware
// (RULE_10) converter may replace external one source
// (RULE_11) serial request is receive OR transmit
// (RULE_12) second serial enable/priority at bit four
// (RULE_13) one priority bit per source, one is high
// (RULE_14) high preempts low; high never preempted
// (RULE_15) higher level wins, then fixed poll order
// (RULE_16) each source gated by own enable bit
// (RULE_17) global enable low acknowledges nothing
// (RULE_18) main enable register bit layout
// (RULE_19) priority registers mirror enable bit layout
// (RULE_20) sample per machine cycle, poll next, forget denied
// (RULE_21) acknowledge calls fixed vector per source
// (RULE_22) return from routine clears current level marker
// (RULE_23) one in-progress marker per priority level

package irq_ctrl_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ENABLE_EXT_ADDR = 8'ha7;
  localparam logic [7:0] ENABLE_MAIN_ADDR = 8'ha8;
  localparam logic [7:0] PRIORITY_EXT_ADDR = 8'hb7;
  localparam logic [7:0] PRIORITY_MAIN_ADDR = 8'hb8;
  // ==========================================================
  // reset values and implemented-bit masks
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MAIN_EN_MASK = 8'hbf;
  localparam logic [7:0] MAIN_PRIO_MASK = 8'h3f;
  localparam logic [7:0] EXT_MASK = 8'h12;
  // ==========================================================
  // field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int TIMER2_BIT = 5;
  localparam int SERIAL_BIT = 4;
  localparam int TIMER1_BIT = 3;
  localparam int EXT1_BIT = 2;
  localparam int TIMER0_BIT = 1;
  localparam int EXT0_BIT = 0;
  localparam int SERIAL2_BIT = 4;
  localparam int TWO_WIRE_BIT = 1;
  // ==========================================================
  // source positions in poll order, 0 polled first
  localparam int NUM_SRC = 10;
  localparam logic [3:0] POS_EXT0 = 4'h0;
  localparam logic [3:0] POS_SERIAL2 = 4'h1;
  localparam logic [3:0] POS_TIMER0 = 4'h2;
  localparam logic [3:0] POS_TWO_WIRE = 4'h3;
  localparam logic [3:0] POS_EXT1 = 4'h4;
  localparam logic [3:0] POS_TIMER1 = 4'h6;
  localparam logic [3:0] POS_SERIAL1 = 4'h8;
  localparam logic [3:0] POS_TIMER2 = 4'h9;
  // ==========================================================
  // vectors
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TIMER0 = 16'h000b;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TIMER1 = 16'h001b;
  localparam logic [15:0] VEC_SERIAL1 = 16'h0023;
  localparam logic [15:0] VEC_TIMER2 = 16'h002b;
  localparam logic [15:0] VEC_TWO_WIRE = 16'h0043;
  localparam logic [15:0] VEC_SERIAL2 = 16'h004b;
  localparam logic [15:0] VEC_NONE = 16'h0000;
endpackage

// ==== src/irq_pick.sv ====
/*
  priority picker: higher level first, then lowest poll position.
  assumes requests already gated by enables; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_pick
(
  // gated requests and their levels
  input wire logic [9:0] req,
  input wire logic [9:0] prio,
  // in-progress markers
  input wire logic busy_hi,
  input wire logic busy_lo,
  // winner
  output logic valid,
  output logic [3:0] idx,
  output logic level
);
  // ==========================================================
  // first set bit from position 0 upward
  function automatic logic [4:0] first_set(input logic [9:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 9; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  logic [4:0] hi_pick;
  logic [4:0] lo_pick;

  // high only blocked by a high routine; low by either
  always_comb
  begin
    hi_pick = first_set(req & prio);
    lo_pick = first_set(req & ~prio);
    valid = 1'b0;
    idx = 4'h0;
    level = 1'b0;
    if (hi_pick[4] && !busy_hi) // RULE_14 RULE_15
    begin
      valid = 1'b1;
      idx = hi_pick[3:0];
      level = 1'b1;
    end
    else if (lo_pick[4] && !busy_hi && !busy_lo) // RULE_23
    begin
      valid = 1'b1;
      idx = lo_pick[3:0];
    end
  end
endmodule
`default_nettype wire

// ==== src/pin_sync.sv ====
/*
  three-stage pin synchroniser with agreement filter.
  assumes an asynchronous pin and one system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pin and filtered level
  input wire logic pin,
  input wire logic idle_level,
  output logic level_q
);
  // ==========================================================
  // stages; the first is seen by the second only
  logic meta_q;
  logic s2_q;
  logic s3_q;

  // shift chain; no reset here, only the filtered level loads the idle level
  always_ff @(posedge clk)
  begin
    meta_q <= pin;
    s2_q <= meta_q;
    s3_q <= s2_q;
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      level_q <= idle_level;
    end
    else if (s2_q == s3_q)
    begin
      level_q <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ==== tb/core_model.sv ====
/*
  core sequencer and peripheral flag model for the interrupt controller.
  assumes the controller's hardware clear pulses last one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module core_model
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench control
  input wire logic run,
  input wire logic [2:0] set,
  // hardware clears from the controller
  input wire logic [2:0] clr,
  // towards the controller
  output logic mc_sample,
  output logic poll_slot,
  output logic [2:0] flag_q
);
  logic [3:0] cnt_q; // phase within a machine cycle

  // ==========================================
  // machine cycle of twelve clocks, cleared to phase zero while stopped
  always_ff @(posedge clk)
  begin
    if (srst || !run)
    begin
      cnt_q <= 4'h0;
    end
    else
    begin
      cnt_q <= (cnt_q == 4'hb) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // sample once per cycle, poll on the last clock
  assign mc_sample = run && (cnt_q == 4'h5);
  assign poll_slot = run && (cnt_q == 4'hb);

  // ==========================================
  // timer and two-wire flags; a clear pulse wins over the set
  always_ff @(posedge clk)
  begin
    flag_q <= srst ? 3'h0 : set & ~clr;
  end
endmodule

`default_nettype wire

// ==== tb/test_two_level_interrupt_controller.sv ====
/*
  self-checking bench for the interrupt controller.
  assumes core_model supplies the sample and poll strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module test_two_level_interrupt_controller;
  logic clk = 0, srst = 1, wr = 0, rdn = 0, run = 0, ret = 0, tk = 0, m3 = 0, alt = 0;
  logic es = 0, x2 = 0; // edge mode; timer two request through its pin
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, d;
  logic [9:0] act = 10'h000; // requests held by the bench, by poll position
  logic ack, f0, f1, t2f, c0, c1, c2, hi, lo, ms, ps, got;
  logic [15:0] vec;
  logic [2:0] fl;
  int mismatches = 0, checked = 0, w;
  // enable/priority bit of each position in {ext, main}
  int ix [10] = '{0, 12, 1, 9, 2, 0, 3, 0, 4, 5};
  logic [15:0] vecs [10] = '{16'h0003, 16'h004b, 16'h000b, 16'h0043, 16'h0013,
    16'h0000, 16'h001b, 16'h0000, 16'h0023, 16'h002b};

  always #5 clk = ~clk;

  irq_ctrl irq_ctrl_i (.SYS_CLK(clk), .SRST(srst), .SFR_ADDR(addr), .SFR_WDATA(wd),
    .SFR_WR(wr), .SFR_RD(rdn), .SFR_RDATA(rdata), .EXT0_PIN_N(~act[0]),
    .EXT1_PIN_N(~(act[4] & ~tk)), .TIMER2_EXT_PIN(~(act[9] & x2)), .EDGE_SELECT_0(es),
    .EDGE_SELECT_1(es), .TIMER0_OVERFLOW_FLAG(fl[0]), .TIMER0_MODE3(m3),
    .TIMER1_OVERFLOW_FLAG(fl[1]), .TIMER2_OVERFLOW_FLAG(act[9] & ~x2),
    .TIMER2_EXT_ENABLE(x2), .TIMER2_EXT_FLAG_CLR(ret), .SERIAL2_EVENT_FLAG(fl[2]),
    .RECEIVE_DONE_FLAG_1(act[8] & alt), .TRANSMIT_DONE_FLAG_1(act[8] & ~alt),
    .RECEIVE_DONE_FLAG_2(act[1] & ~alt), .TRANSMIT_DONE_FLAG_2(act[1] & alt),
    .ADC_TAKEOVER(tk), .ADC_DONE_FLAG(act[4] & tk),
    .MC_SAMPLE(ms), .POLL_SLOT(ps), .RETURN_FROM_IRQ(ret), .IRQ_ACK(ack),
    .IRQ_VECTOR(vec), .EXT_REQUEST_FLAG_0(f0), .EXT_REQUEST_FLAG_1(f1),
    .TIMER2_EXT_FLAG(t2f), .TIMER0_FLAG_CLR(c0), .TIMER1_FLAG_CLR(c1),
    .SERIAL2_EVENT_CLR(c2), .IN_PROGRESS_HI(hi), .IN_PROGRESS_LO(lo));

  core_model core_model_i (.clk(clk), .srst(srst), .run(run), .set({act[3], act[6], act[2]}),
    .clr({c2, c1, c0}), .mc_sample(ms), .poll_slot(ps), .flag_q(fl));

  // ==========================================
  // compare and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // register port, one byte per strobe
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wd = v;
    wr = 1;
    @(negedge clk);
    wr = 0;
    @(negedge clk);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rdn = 1;
    @(negedge clk);
    rdn = 0;
    chk(rdata, e);
    @(negedge clk);
  endtask

  // expected winner: high level first, then lowest position
  function automatic int winner(logic [9:0] a, logic [15:0] en, logic [15:0] pr);
    int r;
    r = -1;
    for (int p = 9; p >= 0; p--)
      if (a[p] && en[ix[p]] && en[7] && (r < 0 || pr[ix[p]] >= pr[ix[r]]))
        r = p;
    return r;
  endfunction

  // one request pattern through sample, poll, ack and return
  task automatic run_case(input logic [9:0] a, input logic [15:0] en, input logic [15:0] pr);
    logic [2:0] fx; // expected pin flags at the acknowledge
    w = winner(a & ~{7'h00, m3, 2'h0}, en, pr);
    wreg(8'ha8, en[7:0]);
    wreg(8'ha7, en[15:8]);
    wreg(8'hb8, pr[7:0]);
    wreg(8'hb7, pr[15:8]);
    act = a;
    repeat (6) @(negedge clk);
    run = 1;
    got = 0;
    for (int i = 0; i < 40 && !got; i++)
    begin
      @(negedge clk);
      got = (ack === 1'b1);
    end
    run = 0;
    act = 10'h000; // requester drops before return
    chk(got, w >= 0);
    fx = {a[0] & ~(es && w == 0), a[4] & ~tk & ~(es && w == 4), a[9] & x2};
    chk({f0, f1, t2f}, fx);
    if (got)
    begin
      chk(vec, vecs[w]);
      chk({c0, c1, c2}, {w == 2, w == 6, w == 3});
      chk({hi, lo}, pr[ix[w]] ? 2'h2 : 2'h1);
    end
    repeat (8) @(negedge clk);
    ret = 1; // the routine also clears the pin flag in software
    es = 0; // level mode flushes an edge flag that was never vectored
    @(negedge clk);
    ret = 0;
    @(negedge clk);
    chk({hi, lo}, 2'h0);
    chk({f0, f1, t2f}, 3'h0);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    void'($urandom(32'h2571));
    repeat (16) @(negedge clk);
    srst = 0;
    @(negedge clk);
    rreg(8'ha7, 8'h00);
    rreg(8'ha8, 8'h00);
    rreg(8'hb7, 8'h00);
    rreg(8'hb8, 8'h00);
    d = $urandom;
    wreg(8'ha7, d);
    rreg(8'ha7, d & irq_ctrl_pkg::EXT_MASK);
    wreg(8'ha8, d);
    rreg(8'ha8, d & irq_ctrl_pkg::MAIN_EN_MASK);
    wreg(8'hb8, d);
    rreg(8'hb8, d & irq_ctrl_pkg::MAIN_PRIO_MASK);
    wreg(8'hb7, d);
    rreg(8'hb7, d & irq_ctrl_pkg::EXT_MASK);
    wreg(8'ha9, 8'hff);
    rreg(8'ha9, 8'h00);
    // corner cases: all at once, one raised high, global off
    run_case(10'h35f, 16'h12bf, 16'h0000);
    run_case(10'h35f, 16'h12bf, 16'h0020);
    run_case(10'h35f, 16'h123f, 16'h123f);
    for (int n = 0; n < 60; n++)
    begin
      tk = $urandom;
      m3 = $urandom;
      alt = $urandom;
      es = $urandom;
      x2 = $urandom;
      run_case($urandom & 10'h35f, $urandom, $urandom);
    end
    summarize();
  end

  // hang guard
  initial
  begin
    #500000;
    mismatches++;
    summarize();
  end
endmodule

`default_nettype wire
